// file: inc/tpcr_pkg.sv
package tpcr_pkg;
  // ****************************************************************
  // Commands
  // ****************************************************************
  typedef enum logic [1:0] {
    TPCR_CMD_SEND_MSG,
    TPCR_CMD_RECV_MSG,
    TPCR_CMD_SEND_STATUS,
    TPCR_CMD_RECV_CMD
  } tpcr_cmd_e;

  // ****************************************************************
  // Outcome codes and steps
  // ****************************************************************
  localparam logic [7:0] CODE_RESET = 8'h01;
  localparam logic [7:0] CODE_MPU_PAR = 8'h22;
  localparam logic [7:0] CODE_SCSI_PAR = 8'h24;
  localparam logic [7:0] CODE_TIMEOUT = 8'h2C;
  localparam logic [7:0] CODE_NORMAL = 8'h60;
  localparam logic [7:0] CODE_ATN = 8'h61;
  localparam logic [7:0] CODE_ATN_MSG = 8'h62;
  localparam logic [7:0] CODE_MSG_LONG = 8'h64;
  localparam logic [7:0] CODE_BAD_GROUP = 8'h65;
  localparam logic [7:0] CODE_ATN_BUSY = 8'h66;
  localparam logic [7:0] CODE_RX_LONG = 8'h67;
  localparam logic [7:0] CODE_RX_BUSY = 8'h6C;
  localparam logic [7:0] STEP_0 = 8'h00;
  localparam logic [7:0] STEP_1 = 8'h01;
  localparam logic [7:0] STEP_2 = 8'h02;

  // ****************************************************************
  // Limits and field positions
  // ****************************************************************
  localparam logic [5:0] MSG_MAX_LEN = 6'd33;
  localparam logic [5:0] MSG_KEEP_BYTES = 6'd2;
  localparam int GROUP_MSB = 7;
  localparam int GROUP_LSB = 5;
  localparam logic [2:0] GRP_3 = 3'h3;
  localparam logic [2:0] GRP_4 = 3'h4;
  localparam logic [2:0] GRP_6 = 3'h6;
  localparam logic [2:0] GRP_7 = 3'h7;
endpackage : tpcr_pkg

// file: inc/tpcr_rpt_if.sv
`timescale 1ns/1ps
interface tpcr_rpt_if;
  logic post;
  logic [7:0] code;
  logic [7:0] step;
  logic busy;
  modport src (output post, output code, output step, input busy);
  modport dst (input post, input code, input step, output busy);
endinterface : tpcr_rpt_if

// file: design/tpcr_report_reg.sv
`timescale 1ns/1ps
module tpcr_report_reg
  import tpcr_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  tpcr_rpt_if.dst rpt,
  input wire logic host_par_err_i,
  output logic [7:0] code_o,
  output logic [7:0] step_o,
  output logic irq_o
);
  logic extra_r;
  logic irq_r;
  logic [7:0] code_r;
  logic [7:0] step_r;

  assign rpt.busy = extra_r;
  assign code_o = code_r;
  assign step_o = step_r;
  assign irq_o = irq_r;

  // Latch each outcome and raise the interrupt for one cycle per outcome
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      code_r <= 8'h00;
      step_r <= 8'h00;
      irq_r <= 1'b0;
    end else if (rpt.post) begin
      code_r <= rpt.code;
      step_r <= rpt.step;
      irq_r <= 1'b1;
    end else if (extra_r) begin
      code_r <= CODE_MPU_PAR;
      step_r <= STEP_0;
      irq_r <= 1'b1;
    end else begin
      irq_r <= 1'b0;
    end
  end

  // Follow-up host parity outcome is queued behind the primary one
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      extra_r <= 1'b0;
    end else if (rpt.post && host_par_err_i) begin
      extra_r <= 1'b1;
    end else if (!rpt.post) begin
      extra_r <= 1'b0;
    end
  end
endmodule : tpcr_report_reg

// file: design/tpcr_top.sv
`timescale 1ns/1ps
module tpcr_top
  import tpcr_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic cmd_start_i,
  input wire logic [1:0] cmd_sel_i,
  input wire logic [5:0] send_len_i,
  input wire logic auto_rx_en_i,
  input wire logic byte_stop_i,
  input wire logic grp67_len_set_i,
  input wire logic bus_reset_i,
  input wire logic atn_i,
  input wire logic rx_buf_busy_i,
  input wire logic timeout_i,
  input wire logic scsi_par_err_i,
  input wire logic host_par_err_i,
  input wire logic byte_done_i,
  input wire logic [7:0] byte_data_i,
  input wire logic block_end_i,
  input wire logic last_byte_i,
  input wire logic exit_done_i,
  output logic xfer_active_o,
  output logic byte_accept_o,
  output logic auto_rx_active_o,
  output logic exit_req_o,
  output logic done_o,
  output logic [7:0] code_o,
  output logic [7:0] step_o,
  output logic irq_o
);
  // ****************************************************************
  // Reset release
  // ****************************************************************
  logic rst_s1_r;
  logic rst_s2_r;

  // Release through two flops so every flop reset by rst_s2_r leaves reset on one edge
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_XFER,
    ST_BLK_WAIT,
    ST_AUTO_RX,
    ST_EXIT,
    ST_POST
  } tpcr_state_e;

  tpcr_state_e state_r;
  tpcr_cmd_e cmd_r;
  logic auto_r;
  logic byte_stop_r;
  logic [5:0] cnt_r;
  logic [7:0] code_r;
  logic [7:0] step_r;
  logic fin_step_r;
  logic is_rx;
  logic is_recv_msg;
  logic is_recv_cmd;
  logic [2:0] grp;
  logic bad_grp;
  tpcr_rpt_if rpt_if ();

  assign is_recv_msg = (cmd_r == TPCR_CMD_RECV_MSG);
  assign is_recv_cmd = (cmd_r == TPCR_CMD_RECV_CMD);
  assign is_rx = is_recv_msg || is_recv_cmd;
  assign grp = byte_data_i[GROUP_MSB:GROUP_LSB];
  // Group 3/4 always unsupported; 6/7 only until lengths are configured
  assign bad_grp = (grp == GRP_3) || (grp == GRP_4)
                   || (((grp == GRP_6) || (grp == GRP_7)) && !grp67_len_set_i);

  // Main command state machine
  always_ff @(posedge ref_clk_i or negedge rst_s2_r) begin
    if (!rst_s2_r) begin
      state_r <= ST_IDLE;
      cmd_r <= TPCR_CMD_SEND_MSG;
      auto_r <= 1'b0;
      byte_stop_r <= 1'b0;
      cnt_r <= 6'd0;
      code_r <= 8'h00;
      step_r <= 8'h00;
      fin_step_r <= 1'b0;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          fin_step_r <= 1'b0;
          if (cmd_start_i) begin
            cmd_r <= tpcr_cmd_e'(cmd_sel_i);
            auto_r <= auto_rx_en_i;
            byte_stop_r <= byte_stop_i;
            cnt_r <= 6'd0;
            if (bus_reset_i) begin
              code_r <= CODE_RESET;
              step_r <= STEP_0;
              state_r <= ST_POST;
            end else if ((tpcr_cmd_e'(cmd_sel_i) == TPCR_CMD_SEND_MSG)
                         && (send_len_i >= MSG_MAX_LEN)) begin
              code_r <= CODE_MSG_LONG;
              step_r <= STEP_1;
              state_r <= ST_POST;
            end else if (((tpcr_cmd_e'(cmd_sel_i) == TPCR_CMD_RECV_MSG)
                          || (tpcr_cmd_e'(cmd_sel_i) == TPCR_CMD_RECV_CMD))
                         && rx_buf_busy_i) begin
              code_r <= CODE_RX_BUSY;
              step_r <= STEP_1;
              state_r <= ST_POST;
            end else begin
              state_r <= ST_XFER;
            end
          end
        end
        ST_XFER, ST_AUTO_RX: begin
          if (bus_reset_i) begin
            code_r <= CODE_RESET;
            step_r <= STEP_1;
            state_r <= ST_EXIT;
          end else if (timeout_i) begin
            code_r <= CODE_TIMEOUT;
            step_r <= STEP_1;
            state_r <= ST_EXIT;
          end else if ((is_rx || state_r == ST_AUTO_RX) && scsi_par_err_i) begin
            code_r <= CODE_SCSI_PAR;
            step_r <= STEP_1;
            // Block mode lets the current block finish first
            state_r <= byte_stop_r ? ST_POST : ST_BLK_WAIT;
          end else if (byte_done_i) begin
            cnt_r <= cnt_r + 6'd1;
            if (state_r == ST_XFER && is_recv_cmd && cnt_r == 6'd0 && bad_grp) begin
              code_r <= CODE_BAD_GROUP;
              step_r <= STEP_1;
              state_r <= ST_POST;
            end else if (state_r == ST_XFER && is_recv_msg
                         && send_len_i >= MSG_MAX_LEN
                         && cnt_r == MSG_KEEP_BYTES - 6'd1) begin
              code_r <= CODE_RX_LONG;
              step_r <= STEP_1;
              state_r <= ST_POST;
            end else if (last_byte_i) begin
              state_r <= ST_POST;
              step_r <= STEP_2;
              if (state_r == ST_AUTO_RX) begin
                code_r <= CODE_ATN_MSG;
              end else if (!atn_i) begin
                code_r <= CODE_NORMAL;
              end else if (is_recv_msg || !auto_r) begin
                code_r <= CODE_ATN;
              end else if (rx_buf_busy_i) begin
                code_r <= CODE_ATN_BUSY;
              end else begin
                cnt_r <= 6'd0;
                state_r <= ST_AUTO_RX;
              end
            end
          end
        end
        ST_BLK_WAIT: begin
          if (block_end_i) begin
            state_r <= ST_POST;
          end
        end
        ST_EXIT: begin
          // Reset and timeout outcomes raised during a transfer wait for exit processing to end
          if (exit_done_i) begin
            state_r <= ST_POST;
          end
        end
        ST_POST: begin
          fin_step_r <= 1'b1;
          state_r <= ST_IDLE;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // Status outputs
  // ****************************************************************
  assign xfer_active_o = (state_r == ST_XFER) || (state_r == ST_AUTO_RX)
                         || (state_r == ST_BLK_WAIT);
  // Bytes keep flowing in block mode until the damaged block has ended
  assign byte_accept_o = (state_r == ST_XFER) || (state_r == ST_AUTO_RX)
                         || (state_r == ST_BLK_WAIT);
  assign auto_rx_active_o = (state_r == ST_AUTO_RX);
  assign exit_req_o = (state_r == ST_EXIT);
  assign done_o = fin_step_r;

  // Report posting: one pulse per outcome
  assign rpt_if.post = (state_r == ST_POST);
  assign rpt_if.code = code_r;
  assign rpt_if.step = step_r;

  tpcr_report_reg u_report (
    .clk_i(ref_clk_i),
    .rst_n_i(rst_s2_r),
    .rpt(rpt_if.dst),
    .host_par_err_i(host_par_err_i),
    .code_o(code_o),
    .step_o(step_o),
    .irq_o(irq_o)
  );
endmodule : tpcr_top

// file: bench/tpcr_checker_assertions.sv
`timescale 1ns/1ps
// ****************
// Outcome checker
// ****************
module tpcr_checker (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic cmd_start_i,
  input wire logic [1:0] cmd_sel_i,
  input wire logic [5:0] send_len_i,
  input wire logic byte_stop_i,
  input wire logic bus_reset_i,
  input wire logic scsi_par_err_i,
  input wire logic host_par_err_i,
  input wire logic exit_done_i,
  input wire logic xfer_active_o,
  input wire logic exit_req_o,
  input wire logic [7:0] code_o,
  input wire logic [7:0] step_o,
  input wire logic irq_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  logic idle;
  // A start only counts when nothing is moving or exiting
  assign idle = !xfer_active_o && !exit_req_o;
  a_reset_before: assert property (cmd_start_i && idle && bus_reset_i |->
    ##2 irq_o && code_o == 8'h01 && step_o == 8'h00) else $error("reset pre-check");
  a_long_refused: assert property (cmd_start_i && idle && !bus_reset_i &&
    cmd_sel_i == 2'h0 && send_len_i >= 6'd33 |-> ##2 irq_o && code_o == 8'h64 &&
    step_o == 8'h01) else $error("long message");
  a_reset_after_exit: assert property (irq_o && code_o == 8'h01 && step_o == 8'h01 |->
    $past(exit_done_i, 2)) else $error("reset before exit");
  a_tmo_after_exit: assert property (irq_o && code_o == 8'h2C |->
    $past(exit_done_i, 2)) else $error("timeout before exit");
  a_byte_stop: assert property (xfer_active_o && byte_stop_i && scsi_par_err_i &&
    cmd_sel_i[0] |=> !xfer_active_o) else $error("byte stop late");
  a_host_extra: assert property (irq_o && $past(host_par_err_i) && code_o != 8'h22 |->
    ##1 irq_o && code_o == 8'h22 && step_o == 8'h00) else $error("host parity");
  a_code_holds: assert property (!irq_o |-> $stable(code_o) && $stable(step_o))
    else $error("outcome moved");
  a_report_idle: assert property (irq_o |-> idle) else $error("report too early");
endmodule : tpcr_checker

bind tpcr_top tpcr_checker u_chk (.ref_clk_i, .rst_n_i, .cmd_start_i, .cmd_sel_i,
  .send_len_i, .byte_stop_i, .bus_reset_i, .scsi_par_err_i, .host_par_err_i,
  .exit_done_i, .xfer_active_o, .exit_req_o, .code_o, .step_o, .irq_o);

// file: bench/tpcr_init_model.sv
`timescale 1ns/1ps
// ****************
// Initiator model
// ****************
// One byte every other cycle while accepted and not stalled; a fresh message follows each
// last byte, so an automatic receive always finds one waiting.
module tpcr_init_model (
  input wire logic clk_i,
  input wire logic accept_i,
  input wire logic stall_i,
  input wire logic [5:0] len_i,
  input wire logic [7:0] op_i,
  output logic done_o,
  output logic last_o,
  output logic [7:0] data_o
);
  logic [5:0] cnt_r = 6'h00;
  logic send;
  assign send = accept_i && !stall_i && !done_o;
  // Unstrobed data flips each cycle so a stale byte never looks valid
  always @(negedge clk_i) begin
    done_o <= send;
    last_o <= send && cnt_r == len_i - 6'h01;
    data_o <= send ? op_i + {2'h0, cnt_r} : ~data_o;
    if (!accept_i) cnt_r <= 6'h00;
    else if (send) cnt_r <= (cnt_r == len_i - 6'h01) ? 6'h00 : cnt_r + 6'h01;
  end
  initial begin
    done_o = 1'b0;
    last_o = 1'b0;
    data_o = 8'h00;
  end
endmodule : tpcr_init_model

// file: bench/testbench.sv
`timescale 1ns/1ps
// ****************
// Outcome scenarios
// ****************
module testbench;
  logic ref_clk_i = 1'b0, rst_n_i = 1'b0, cmd_start_i = 1'b0, stall = 1'b0;
  logic [1:0] cmd_sel_i = 2'h0;
  logic [5:0] send_len_i = 6'h01;
  logic auto_rx_en_i = 1'b0, byte_stop_i = 1'b1, grp67_len_set_i = 1'b0, bus_reset_i = 1'b0;
  logic atn_i = 1'b0, rx_buf_busy_i = 1'b0, timeout_i = 1'b0, scsi_par_err_i = 1'b0;
  logic host_par_err_i = 1'b0, block_end_i = 1'b0, exit_done_i = 1'b0;
  logic byte_done_i, last_byte_i, xfer_active_o, byte_accept_o, exit_req_o, done_o, irq_o;
  logic auto_rx_active_o, auto_seen = 1'b0;
  logic [7:0] byte_data_i, code_o, step_o;
  logic [7:0] op = 8'h00;
  int failures = 0, checks = 0, nacc = 0;
  tpcr_top u_dut (.ref_clk_i, .rst_n_i, .cmd_start_i, .cmd_sel_i, .send_len_i, .auto_rx_en_i,
    .byte_stop_i, .grp67_len_set_i, .bus_reset_i, .atn_i, .rx_buf_busy_i, .timeout_i,
    .scsi_par_err_i, .host_par_err_i, .byte_done_i, .byte_data_i, .block_end_i, .last_byte_i,
    .exit_done_i, .xfer_active_o, .byte_accept_o, .auto_rx_active_o, .exit_req_o, .done_o,
    .code_o, .step_o, .irq_o);
  tpcr_init_model u_init (.clk_i(ref_clk_i), .accept_i(byte_accept_o), .stall_i(stall),
    .len_i(send_len_i), .op_i(op), .done_o(byte_done_i), .last_o(last_byte_i),
    .data_o(byte_data_i));
  always #10 ref_clk_i = ~ref_clk_i;
  // Exit processing is granted half a cycle after it is asked for
  always @(negedge ref_clk_i) exit_done_i <= exit_req_o && !exit_done_i;
  // Bytes the block really took in
  always @(posedge ref_clk_i) if (byte_done_i && byte_accept_o) nacc++;
  // Whether an automatic receive was entered during the current command
  always @(posedge ref_clk_i) if (auto_rx_active_o) auto_seen = 1'b1;
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic stop_test();
    if (failures == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : stop_test
  // Start, optionally disturb (1 reset, 2 timeout, 3/4 parity, 5 unstalled timeout plus parity), judge
  task automatic run(input logic [1:0] sel, input logic [5:0] len, input logic [7:0] ec,
                     input logic [7:0] es, input int ev = 0);
    int n = 0;
    repeat (3) @(negedge ref_clk_i);
    stall = ev > 0 && ev < 5;
    cmd_sel_i = sel;
    send_len_i = len;
    nacc = 0;
    auto_seen = 1'b0;
    cmd_start_i = 1'b1;
    @(negedge ref_clk_i);
    cmd_start_i = 1'b0;
    @(negedge ref_clk_i);
    bus_reset_i = bus_reset_i || ev == 1;
    timeout_i = ev == 2 || ev == 5;
    scsi_par_err_i = ev > 2;
    if (ev == 4) begin
      repeat (8) @(negedge ref_clk_i);
      chk({7'h00, xfer_active_o}, 8'h01, "block");
      chk({7'h00, byte_accept_o}, 8'h01, "accept");
      block_end_i = 1'b1;
      @(negedge ref_clk_i);
      block_end_i = 1'b0;
    end
    while (irq_o !== 1'b1 && n < 200) begin
      @(negedge ref_clk_i);
      n++;
    end
    if (n == 200) failures++;
    if (n == 200) stop_test();
    chk(code_o, ec, "code");
    chk(step_o, es, "step");
    chk({7'h00, done_o}, 8'h01, "done");
    if (ev > 0) {bus_reset_i, timeout_i, scsi_par_err_i, stall} = 4'h0;
  endtask : run
  task automatic s_normal();
    for (int c = 0; c < 4; c++) run(c[1:0], 6'd3, 8'h60, 8'h02);
  endtask : s_normal
  task automatic s_atn();
    atn_i = 1'b1;
    for (int c = 0; c < 4; c++) run(c[1:0], 6'd2, 8'h61, 8'h02);
    auto_rx_en_i = 1'b1;
    run(2'h1, 6'd2, 8'h61, 8'h02);
    run(2'h2, 6'd2, 8'h62, 8'h02);
    chk({7'h00, auto_seen}, 8'h01, "auto");
    run(2'h2, 6'd1, 8'h2C, 8'h01, 5);
    chk({7'h00, auto_seen}, 8'h01, "auto");
    rx_buf_busy_i = 1'b1;
    run(2'h0, 6'd2, 8'h66, 8'h02);
    chk({7'h00, auto_seen}, 8'h00, "auto");
    {atn_i, auto_rx_en_i} = 2'h0;
    run(2'h1, 6'd2, 8'h6C, 8'h01);
    run(2'h3, 6'd2, 8'h6C, 8'h01);
    rx_buf_busy_i = 1'b0;
  endtask : s_atn
  task automatic s_len();
    run(2'h0, 6'd33, 8'h64, 8'h01);
    chk(8'(nacc), 8'h00, "bytes");
    run(2'h0, 6'd32, 8'h60, 8'h02);
    run(2'h1, 6'd33, 8'h67, 8'h01);
    chk(8'(nacc), 8'h02, "bytes");
  endtask : s_len
  task automatic s_group();
    for (int g = 3; g < 8; g++) begin
      op = {g[2:0], 5'h00};
      grp67_len_set_i = 1'b0;
      if (g != 5) run(2'h3, 6'd4, 8'h65, 8'h01);
      if (g != 5) chk(8'(nacc), 8'h01, "bytes");
      grp67_len_set_i = 1'b1;
      if (g > 5) run(2'h3, 6'd1, 8'h60, 8'h02);
    end
    op = 8'h00;
  endtask : s_group
  task automatic s_abort();
    bus_reset_i = 1'b1;
    for (int c = 0; c < 4; c++) run(c[1:0], 6'd2, 8'h01, 8'h00);
    bus_reset_i = 1'b0;
    run(2'h2, 6'd2, 8'h01, 8'h01, 1);
    run(2'h3, 6'd2, 8'h2C, 8'h01, 2);
    run(2'h1, 6'd4, 8'h24, 8'h01, 3);
    byte_stop_i = 1'b0;
    run(2'h3, 6'd4, 8'h24, 8'h01, 4);
    byte_stop_i = 1'b1;
  endtask : s_abort
  task automatic s_host();
    host_par_err_i = 1'b1;
    run(2'h2, 6'd2, 8'h60, 8'h02);
    host_par_err_i = 1'b0;
    @(negedge ref_clk_i);
    chk({irq_o, code_o[6:0]}, 8'hA2, "code");
    chk(step_o, 8'h00, "step");
  endtask : s_host
  initial begin
    repeat (3) @(negedge ref_clk_i);
    rst_n_i = 1'b1;
    s_normal();
    s_atn();
    s_len();
    s_group();
    s_abort();
    s_host();
    stop_test();
  end
endmodule : testbench
